// *** sac_adc_ctrl.v ***
// Control and configuration logic of a 10-bit SAR converter
`timescale 1ns/100ps
`include "sac_consts.vh"

// Behaviour
// - Upper nibble of pair/channel registers reads zero
// - Pair bit one makes even/odd differential pair
// - Differential channel gives two's complement result
// - Codes 0-7 select input, 1xxx temperature
// - Nonzero divider: SAR period 2(D+1) clocks
// - Divider zero: SAR clock equals system clock
// - Gain code mapping, 10x sixteen, 11x half
// - Enable bit clear holds analog in shutdown
// - Track mode zero: track except converting
// - Done flag set on busy fall, software clears
// - Busy bit high whole conversion
// - Busy write one starts only mode 00
// - Four start sources by start mode code
// - Low-power tracking: three SAR clocks, then convert
// - Low-power pin mode: track while pin low
// - Window flag set on match, software clears
// - Justify bit selects right or left placement
// - Left justify: high holds eight top bits
// - Right justify: sign extend differential, else zero
// - Conversion lasts sixteen SAR clocks
module sac_adc_ctrl (
  // Clock and reset
  input wire clk,
  input wire arst_n,

  // Special-function-register bus
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata,

  // Start sources
  input wire tmr2_ovf,
  input wire tmr3_ovf,
  input wire external_convert_start,

  // Analog core interface
  input wire [9:0] sar_word,
  input wire window_match,
  output reg converter_enable,
  output reg track_en,
  output reg convert_en,
  output reg sar_clk_tick,
  output reg [3:0] mux_pos_sel,
  output reg mux_diff,
  output reg [2:0] amplifier_gain_code,

  // Result word
  output reg [7:0] result_high,
  output reg [7:0] result_low,
  output reg result_valid
);

  // One-hot sequencer states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_TRACK = 3'b010;
  localparam [2:0] ST_CONV = 3'b100;

  reg rst_meta_reg;
  reg rst_n_sync;
  reg [3:0] input_pair_config_reg;
  reg [3:0] channel_select_reg;
  reg [7:0] conversion_config_reg;
  reg [7:0] ctrl_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [5:0] div_cnt_reg;
  reg [4:0] sar_cnt_reg;
  reg [4:0] sar_cnt_next;
  reg pin_meta_reg;
  reg pin_sync_reg;
  reg pin_prev_reg;
  reg trigger;
  reg done_set;

  wire [4:0] sar_clock_divider;
  wire [1:0] start_mode_select;
  wire ctrl_wr;
  wire soft_start;
  wire pin_rise;
  wire sel_diff;
  wire busy;
  wire [5:0] div_last;

  // Reset release through two flip-flops
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_sync <= rst_meta_reg;
    end
  end

  // Field views
  assign sar_clock_divider = conversion_config_reg[`SAC_CFG_DIV_HI:`SAC_CFG_DIV_LO];
  assign start_mode_select = ctrl_reg[`SAC_CN_CM_HI:`SAC_CN_CM_LO];
  assign ctrl_wr = sfr_wr && (sfr_addr == `SAC_ADDR_CTRL);
  assign busy = state_reg != ST_IDLE;

  // Busy write of one, honoured only in software mode
  assign soft_start = ctrl_wr && sfr_wdata[`SAC_CN_BUSY] &&
                      (sfr_wdata[`SAC_CN_CM_HI:`SAC_CN_CM_LO] == `SAC_CM_SOFT);

  // Selected channel is differential when its pair bit is set
  assign sel_diff = !channel_select_reg[3] &&
                    input_pair_config_reg[channel_select_reg[2:1]];

  // Start pin synchroniser and rising edge
  always @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= external_convert_start;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign pin_rise = pin_sync_reg && !pin_prev_reg;

  // SAR clock divider: tick every 2(D+1) cycles, or every cycle at zero
  assign div_last = {sar_clock_divider, 1'b1};

  always @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      div_cnt_reg <= 6'h00;
      sar_clk_tick <= 1'b0;
    end else if (sar_clock_divider == 5'h00) begin
      div_cnt_reg <= 6'h00;
      sar_clk_tick <= 1'b1;
    end else if (div_cnt_reg >= div_last) begin
      div_cnt_reg <= 6'h00;
      sar_clk_tick <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 6'h01;
      sar_clk_tick <= 1'b0;
    end
  end

  // Start source selection
  always @* begin
    case (start_mode_select)
      `SAC_CM_SOFT: trigger = soft_start;
      `SAC_CM_TMR3: trigger = tmr3_ovf;
      `SAC_CM_PIN: trigger = pin_rise;
      `SAC_CM_TMR2: trigger = tmr2_ovf;
      default: trigger = 1'b0;
    endcase
  end

  // Conversion sequencer
  always @* begin
    state_next = state_reg;
    sar_cnt_next = sar_cnt_reg;
    done_set = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        sar_cnt_next = 5'h00;
        if (ctrl_reg[`SAC_CN_EN] && trigger) begin
          if (ctrl_reg[`SAC_CN_TM] && start_mode_select != `SAC_CM_PIN)
            state_next = ST_TRACK;
          else
            state_next = ST_CONV;
        end
      end
      ST_TRACK: begin
        if (sar_clk_tick) begin
          if (sar_cnt_reg == `SAC_TRACK_CLKS - 5'h01) begin
            sar_cnt_next = 5'h00;
            state_next = ST_CONV;
          end else begin
            sar_cnt_next = sar_cnt_reg + 5'h01;
          end
        end
      end
      ST_CONV: begin
        if (sar_clk_tick) begin
          if (sar_cnt_reg == `SAC_CONV_CLKS - 5'h01) begin
            sar_cnt_next = 5'h00;
            state_next = ST_IDLE;
            done_set = 1'b1;
          end else begin
            sar_cnt_next = sar_cnt_reg + 5'h01;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
        sar_cnt_next = 5'h00;
      end
    endcase
    if (!ctrl_reg[`SAC_CN_EN]) begin
      state_next = ST_IDLE;
      sar_cnt_next = 5'h00;
      done_set = 1'b0;
    end
  end

  always @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_reg <= ST_IDLE;
      sar_cnt_reg <= 5'h00;
    end else begin
      state_reg <= state_next;
      sar_cnt_reg <= sar_cnt_next;
    end
  end

  // Register writes; hardware flag sets win over software clears
  always @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      input_pair_config_reg <= `SAC_RST_PAIR;
      channel_select_reg <= `SAC_RST_CHSEL;
      conversion_config_reg <= `SAC_RST_CFG;
      ctrl_reg <= `SAC_RST_CTRL;
    end else begin
      if (sfr_wr && sfr_addr == `SAC_ADDR_PAIR)
        input_pair_config_reg <= sfr_wdata[3:0];
      if (sfr_wr && sfr_addr == `SAC_ADDR_CHSEL)
        channel_select_reg <= sfr_wdata[3:0];
      if (sfr_wr && sfr_addr == `SAC_ADDR_CFG)
        conversion_config_reg <= sfr_wdata;
      if (ctrl_wr) begin
        ctrl_reg[7:6] <= sfr_wdata[7:6];
        ctrl_reg[3:2] <= sfr_wdata[3:2];
        ctrl_reg[`SAC_CN_LJST] <= sfr_wdata[`SAC_CN_LJST];
        ctrl_reg[`SAC_CN_DONE] <= sfr_wdata[`SAC_CN_DONE] | done_set;
        ctrl_reg[`SAC_CN_WIN] <= sfr_wdata[`SAC_CN_WIN] | window_match;
      end else begin
        if (done_set)
          ctrl_reg[`SAC_CN_DONE] <= 1'b1;
        if (window_match)
          ctrl_reg[`SAC_CN_WIN] <= 1'b1;
      end
      ctrl_reg[`SAC_CN_BUSY] <= 1'b0;
    end
  end

  // Result capture and justification; software may also write
  always @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      result_high <= `SAC_RST_RES;
      result_low <= `SAC_RST_RES;
      result_valid <= 1'b0;
    end else begin
      result_valid <= done_set;
      if (done_set) begin
        if (ctrl_reg[`SAC_CN_LJST]) begin
          result_high <= sar_word[9:2];
          result_low <= {sar_word[1:0], 6'h00};
        end else begin
          result_high <= {{6{sel_diff & sar_word[9]}}, sar_word[9:8]};
          result_low <= sar_word[7:0];
        end
      end else begin
        if (sfr_wr && sfr_addr == `SAC_ADDR_RHIGH)
          result_high <= sfr_wdata;
        if (sfr_wr && sfr_addr == `SAC_ADDR_RLOW)
          result_low <= sfr_wdata;
      end
    end
  end

  // Registered read port; unmapped addresses read zero
  always @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `SAC_ADDR_PAIR: sfr_rdata <= {4'h0, input_pair_config_reg};
        `SAC_ADDR_CHSEL: sfr_rdata <= {4'h0, channel_select_reg};
        `SAC_ADDR_CFG: sfr_rdata <= conversion_config_reg;
        `SAC_ADDR_RLOW: sfr_rdata <= result_low;
        `SAC_ADDR_RHIGH: sfr_rdata <= result_high;
        `SAC_ADDR_CTRL: sfr_rdata <= {ctrl_reg[7:5], busy, ctrl_reg[3:0]};
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  // Analog control outputs
  always @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      converter_enable <= 1'b0;
      track_en <= 1'b0;
      convert_en <= 1'b0;
      mux_pos_sel <= 4'h0;
      mux_diff <= 1'b0;
      amplifier_gain_code <= 3'h0;
    end else begin
      converter_enable <= ctrl_reg[`SAC_CN_EN];
      convert_en <= state_next == ST_CONV;
      if (!ctrl_reg[`SAC_CN_EN])
        track_en <= 1'b0;
      else if (!ctrl_reg[`SAC_CN_TM])
        track_en <= state_next != ST_CONV;
      else if (start_mode_select == `SAC_CM_PIN)
        track_en <= state_next == ST_IDLE && !pin_sync_reg;
      else
        track_en <= state_next == ST_TRACK;
      if (channel_select_reg[3])
        mux_pos_sel <= 4'h8;
      else if (sel_diff)
        mux_pos_sel <= {1'b0, channel_select_reg[2:1], 1'b0};
      else
        mux_pos_sel <= {1'b0, channel_select_reg[2:0]};
      mux_diff <= sel_diff;
      amplifier_gain_code <=
        conversion_config_reg[`SAC_CFG_GAIN_HI:`SAC_CFG_GAIN_LO];
    end
  end

endmodule

// *** sac_adc_ctrl_bench.sv ***
// Self-checking testbench for the converter control block
`timescale 1ns/100ps
module sac_adc_ctrl_bench;
  reg clk = 0, arst_n = 0, wr = 0, rd = 0, t2 = 0, t3 = 0, pin = 0, win = 0;
  reg [7:0] addr = 0, wdata = 0, v;
  reg [9:0] word = 0;
  wire [7:0] rdata, rh, rl;
  wire [3:0] pos;
  wire [2:0] gain;
  wire en, trk, cnv, tick, diff, rv;
  integer mismatches = 0, samples_checked = 0, i, n;
  // Cycles with convert_en high in the current run
  integer conv_len = 0;
  reg slow = 0;
  // System clock, 4 ns
  always #2 clk = ~clk;
  // Conversion length in system cycles
  always @(negedge clk)
    if (cnv === 1'b1)
      conv_len = conv_len + 1;
  sac_adc_ctrl dut_u (.clk(clk), .arst_n(arst_n), .sfr_addr(addr), .sfr_wdata(wdata),
    .sfr_wr(wr), .sfr_rd(rd), .sfr_rdata(rdata), .tmr2_ovf(t2), .tmr3_ovf(t3),
    .external_convert_start(pin), .sar_word(word), .window_match(win),
    .converter_enable(en), .track_en(trk), .convert_en(cnv), .sar_clk_tick(tick),
    .mux_pos_sel(pos), .mux_diff(diff), .amplifier_gain_code(gain),
    .result_high(rh), .result_low(rl), .result_valid(rv));
  // Compare and count
  task check(input [79:0] what, input [7:0] seen, input [7:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== e) begin
        mismatches = mismatches + 1;
        $display("BAD %0s expected %h seen %h", what, e, seen);
      end
    end
  endtask
  // Register write, one strobe cycle
  task wr_reg(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1;
      @(negedge clk);
      wr = 0;
    end
  endtask
  // Register read and compare
  task rd_reg(input [7:0] a, input [7:0] e);
    begin
      @(negedge clk);
      addr = a;
      rd = 1;
      @(negedge clk);
      rd = 0;
      @(negedge clk);
      check("sfr_read", rdata, e);
    end
  endtask
  // Cycles between two SAR ticks
  task gap(input [7:0] e);
    begin
      n = 0;
      while (tick !== 1'b1 && n < 100) begin
        @(negedge clk);
        n = n + 1;
      end
      n = 1;
      @(negedge clk);
      while (tick !== 1'b1 && n < 100) begin
        @(negedge clk);
        n = n + 1;
      end
      check("tick_gap", n[7:0], e);
    end
  endtask
  // One conversion from the source in ctl, then result and flag readback
  task run(input [7:0] ch, input [9:0] w, input [7:0] ctl, input [7:0] eh, input [7:0] el);
    begin
      word = w;
      wr_reg(8'hbb, ch);
      // Enable first: a start only counts once the enable bit stands
      wr_reg(8'he8, ctl & 8'hef);
      conv_len = 0;
      wr_reg(8'he8, ctl);
      @(negedge clk);
      t3 = ctl[3:2] == 2'h1;
      t2 = ctl[3:2] == 2'h3;
      pin = ctl[3:2] == 2'h2;
      @(negedge clk);
      t2 = 0;
      t3 = 0;
      n = 0;
      while (rv !== 1'b1 && n < 2000) begin
        @(negedge clk);
        n = n + 1;
      end
      check("done", {7'h00, rv}, 8'h01);
      // Sixteen SAR clocks: 64 cycles each when slow, one each otherwise
      if (slow)
        check("conv_len", {7'h00, conv_len >= 961 && conv_len <= 1024}, 8'h01);
      else
        check("conv_len", conv_len[7:0], 8'h10);
      pin = 0;
      rd_reg(8'hbf, eh);
      rd_reg(8'hbe, el);
      rd_reg(8'he8, (ctl & 8'hef) | 8'h20);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // Watchdog against a hang
  initial begin
    #80000;
    mismatches = mismatches + 1;
    tally_and_finish;
  end
  // Test sequence
  initial begin
    repeat (20) @(negedge clk);
    arst_n = 1;
    repeat (3) @(negedge clk);
    rd_reg(8'hba, 8'h00);
    rd_reg(8'hbc, 8'hf8);
    rd_reg(8'hbf, 8'h00);
    rd_reg(8'he8, 8'h00);
    rd_reg(8'hbd, 8'h00);
    wr_reg(8'hba, 8'hf5);
    rd_reg(8'hba, 8'h05);
    $display("test reset and readback done");
    for (i = 0; i < 8; i = i + 1) begin
      wr_reg(8'hbc, i[7:0]);
      @(negedge clk);
      check("gain", {5'h00, gain}, i[7:0]);
    end
    wr_reg(8'hbc, 8'h10);
    gap(8'h06);
    wr_reg(8'hbc, 8'h00);
    gap(8'h01);
    $display("test gain and divider done");
    for (i = 0; i < 10; i = i + 1) begin
      wr_reg(8'hbb, i[7:0]);
      @(negedge clk);
      check("mux_sel", {4'h0, pos}, i > 7 ? 8'h08 : (i[1] ? i[7:0] : i[7:0] & 8'hfe));
      check("mux_diff", {7'h00, diff}, {7'h00, i < 8 && !i[1]});
    end
    $display("test multiplexer done");
    run(8'h01, 10'h3ff, 8'h90, 8'hff, 8'hff);
    run(8'h00, 10'h201, 8'hc5, 8'h80, 8'h40);
    run(8'h02, 10'h201, 8'h88, 8'h02, 8'h01);
    run(8'h03, 10'h155, 8'hcc, 8'h01, 8'h55);
    check("track", {7'h00, trk}, 8'h00);
    // Slowest SAR clock the divider offers
    wr_reg(8'hbc, 8'hf8);
    slow = 1;
    run(8'h03, 10'h155, 8'hc8, 8'h01, 8'h55);
    check("track", {7'h00, trk}, 8'h01);
    $display("test conversions done");
    wr_reg(8'he8, 8'h94);
    rd_reg(8'he8, 8'h84);
    check("track", {7'h00, trk}, 8'h01);
    wr_reg(8'he8, 8'h10);
    rd_reg(8'he8, 8'h00);
    check("enable", {7'h00, en}, 8'h00);
    @(negedge clk);
    win = 1;
    @(negedge clk);
    win = 0;
    rd_reg(8'he8, 8'h02);
    wr_reg(8'he8, 8'h00);
    rd_reg(8'he8, 8'h00);
    $display("test refusals and flags done");
    tally_and_finish;
  end
endmodule

// *** sac_adc_ctrl_properties.sv ***
// Port-level checker for the converter control block
`timescale 1ns/100ps
module sac_adc_checker (
  // Clock, reset and bus
  input wire clk,
  input wire arst_n,
  input wire [7:0] sfr_addr,
  input wire sfr_rd,
  input wire sfr_wr,
  input wire [7:0] sfr_rdata,
  // Converter side
  input wire converter_enable,
  input wire track_en,
  input wire convert_en,
  input wire [3:0] mux_pos_sel,
  input wire mux_diff,
  input wire [7:0] result_high,
  input wire result_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_no_track_conv: assert property (convert_en |-> !track_en)
    else $error("tracking while converting");
  a_off_idle: assert property (!converter_enable && !$past(converter_enable) |-> !convert_en)
    else $error("converting while disabled");
  a_conv_min_len: assert property ($rose(convert_en) |-> convert_en [*8])
    else $error("conversion too short");
  a_valid_cause: assert property (result_valid |-> $past(convert_en) || $past(convert_en, 2))
    else $error("result without conversion");
  a_valid_pulse: assert property (result_valid |=> !result_valid)
    else $error("result pulse too long");
  a_temp_code: assert property (mux_pos_sel[3] |-> mux_pos_sel[2:0] == 3'h0)
    else $error("bad temperature select");
  a_diff_even: assert property (mux_diff |-> !mux_pos_sel[0] && !mux_pos_sel[3])
    else $error("differential select not even");
  a_result_hold: assert property ($changed(result_high) |-> result_valid || $past(sfr_wr))
    else $error("result changed without cause");
  a_upper_zero: assert property (
    $past(sfr_rd) && $past(sfr_addr[7:1]) == 7'h5d |-> sfr_rdata[7:4] == 4'h0)
    else $error("upper nibble not zero");
endmodule
bind sac_adc_ctrl sac_adc_checker chk_u (.clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr),
  .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata), .converter_enable(converter_enable),
  .track_en(track_en), .convert_en(convert_en), .mux_pos_sel(mux_pos_sel), .mux_diff(mux_diff),
  .result_high(result_high), .result_valid(result_valid));

// *** sac_consts.vh ***
// Register offsets, field positions, reset values and timing counts
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH

// Register addresses
`define SAC_ADDR_PAIR 8'hba
`define SAC_ADDR_CHSEL 8'hbb
`define SAC_ADDR_CFG 8'hbc
`define SAC_ADDR_RLOW 8'hbe
`define SAC_ADDR_RHIGH 8'hbf
`define SAC_ADDR_CTRL 8'he8

// Reset values
`define SAC_RST_PAIR 4'h0
`define SAC_RST_CHSEL 4'h0
`define SAC_RST_CFG 8'hf8
`define SAC_RST_RES 8'h00
`define SAC_RST_CTRL 8'h00

// Configuration register fields
`define SAC_CFG_DIV_HI 7
`define SAC_CFG_DIV_LO 3
`define SAC_CFG_GAIN_HI 2
`define SAC_CFG_GAIN_LO 0

// Control register bits
`define SAC_CN_EN 7
`define SAC_CN_TM 6
`define SAC_CN_DONE 5
`define SAC_CN_BUSY 4
`define SAC_CN_CM_HI 3
`define SAC_CN_CM_LO 2
`define SAC_CN_WIN 1
`define SAC_CN_LJST 0

// Start mode codes
`define SAC_CM_SOFT 2'h0
`define SAC_CM_TMR3 2'h1
`define SAC_CM_PIN 2'h2
`define SAC_CM_TMR2 2'h3

// Timing in SAR clocks
`define SAC_TRACK_CLKS 5'h03
`define SAC_CONV_CLKS 5'h10

`endif
